/* File: bench/eew_host_tb.sv */
`timescale 1ns/1ps
module eew_host_tb;
  import eew_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  logic ce_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic scl_o;
  logic sda_o;
  logic sda_oe_n_o;
  logic mem_pull;
  logic sda_wire;
  int mismatches;
  int checks;

  // The pull-up wins whenever neither end pulls the line low.
  assign sda_wire = (sda_oe_n_o === 1'b0 || mem_pull === 1'b1) ? 1'b0 : 1'b1;

  eew_host dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_o(scl_o),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));

  eew_mem_model #(.BUSY_NS(300000)) mem_dev (.scl_i(scl_o), .sda_i(sda_wire),
    .pull_o(mem_pull));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // Status is polled sparsely; a whole command takes tens of thousands of cycles.
  task automatic wait_idle();
    logic [31:0] st;
    st = 32'h1;
    for (int i = 0; i < 1000 && st[ST_BUSY_BIT] !== 1'b0; i++)
    begin
      repeat (100) @(posedge mclk_i);
      rd(REG_STATUS, st);
    end
    if (st[ST_BUSY_BIT] !== 1'b0)
      mismatches++;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(scl_o, 1'b1);
    chk(sda_oe_n_o, 1'b1);
    chk(sda_o, 1'b0);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_LEN, 32'h1);
    @(posedge mclk_i);
    #1;
    chk(rdata_o, 32'h0);
    rd_chk(REG_WADDR, 32'h0);
    rd_chk(8'h14, 32'h0);
    wr(REG_LEN, 32'h0);
    rd_chk(REG_LEN, 32'h1);
    wr(REG_LEN, 32'h11);
    rd_chk(REG_LEN, 32'h10);
    wr(REG_LEN, 32'h1);
    wr(REG_CMD, 32'h03);
    rd_chk(REG_STATUS, 32'h0);
  endtask

  // A read frame is frozen by the enable in its start, then cut by reset.
  // Releasing data under a high clock there reads as a stop to the memory.
  task automatic t_cut_frame();
    wr(REG_CMD, 32'h16);
    repeat (1000) @(posedge mclk_i);
    #1;
    chk(scl_o, 1'b1);
    chk(sda_oe_n_o, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    repeat (2000) @(posedge mclk_i);
    #1;
    chk(scl_o, 1'b1);
    chk(sda_oe_n_o, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk(scl_o, 1'b1);
    chk(sda_oe_n_o, 1'b1);
    rd_chk(REG_STATUS, 32'h0);
  endtask

  task automatic t_poll_idle();
    wr(REG_CMD, 32'h0D);
    rd_chk(REG_STATUS, 32'h1);
    wait_idle();
    rd_chk(REG_STATUS, 32'h0);
  endtask

  task automatic t_byte_write();
    wr(REG_WADDR, 32'h3F);
    wr(REG_TXDATA, 32'h5A);
    rd_chk(REG_STATUS, 32'h10);
    wr(REG_CMD, 32'h14);
    wr(REG_WADDR, 32'h00);
    wait_idle();
    rd_chk(REG_WADDR, 32'h30);
    rd_chk(REG_STATUS, 32'h0);
    chk(mem_dev.cells[11'h53F], 8'h5A);
    chk(mem_dev.busy, 1'b1);
  endtask

  task automatic t_poll_busy();
    wr(REG_CMD, 32'h15);
    wait_idle();
    rd_chk(REG_STATUS, 32'h2);
    chk(mem_dev.errs, 32'h0);
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial
    mclk_i = 1'b0;

  always #2.5 mclk_i = ~mclk_i;

  initial
  begin
    mismatches = 0;
    checks = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    t_reset();
    t_poll_idle();
    t_cut_frame();
    t_byte_write();
    t_poll_busy();
    close_out();
  end

  initial
  begin
    #540000;
    mismatches++;
    close_out();
  end
endmodule

/* File: bench/eew_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Behavioural two-wire memory: write path and acknowledge polling
// ****************************************************************
// Reads are not modelled, so a read control byte is left unacknowledged.
module eew_mem_model #(
  parameter int BUSY_NS = 300000
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic pull_o
);
  logic [7:0] cells [0:2047];
  logic [7:0] page [0:15];
  logic [15:0] mask;
  logic [10:0] ptr;
  logic [7:0] shreg;
  logic active;
  logic busy;
  int nbit;
  int phase;
  int errs;
  event go_busy;

  initial
  begin
    for (int i = 0; i < 2048; i++)
      cells[i] = 8'hFF;
    pull_o = 1'b0;
    mask = '0;
    ptr = '0;
    shreg = '0;
    active = 1'b0;
    busy = 1'b0;
    nbit = 0;
    phase = 0;
    errs = 0;
  end

  // A start inside an open transfer means the host skipped its stop.
  always @(negedge sda_i)
  begin
    if (scl_i === 1'b1)
    begin
      if (active)
        errs++;
      active = 1'b1;
      nbit = 0;
      phase = 0;
      pull_o = 1'b0;
    end
  end

  always @(posedge sda_i)
  begin
    if (scl_i === 1'b1)
    begin
      if (phase == 2 && mask != '0)
      begin
        for (int i = 0; i < 16; i++)
          if (mask[i])
            cells[{ptr[10:4], i[3:0]}] = page[i];
        -> go_busy;
      end
      active = 1'b0;
      mask = '0;
      phase = 0;
    end
  end

  always @(posedge scl_i)
  begin
    if (active)
    begin
      if (nbit < 8)
      begin
        shreg = {shreg[6:0], sda_i};
        nbit++;
      end
      else
        nbit = 0;
    end
  end

  always @(negedge scl_i)
  begin
    if (active && nbit == 8)
    begin
      if (phase == 0)
      begin
        active = !busy && shreg[7:4] == 4'hA && !shreg[0];
        ptr[10:8] = shreg[3:1];
        phase = 1;
      end
      else if (phase == 1)
      begin
        ptr[7:0] = shreg;
        phase = 2;
      end
      else
      begin
        page[ptr[3:0]] = shreg;
        mask[ptr[3:0]] = 1'b1;
        ptr[3:0] = ptr[3:0] + 4'h1;
      end
      pull_o = active;
    end
    else
      pull_o = 1'b0;
  end

  always
  begin
    @(go_busy);
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
endmodule

/* File: rtl/eew_host.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Data changes only while clock is low, except start and stop.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop.
// - Every command opens with a start and ends with a stop.
// - A transfer begins only with data and clock both high.
// - One clock pulse per bit, data stable through the high phase.
// - Every byte gets a ninth clock pulse for its acknowledge.
// - The acknowledger holds data low across the ninth high phase.
// - On reads the last byte is left unacknowledged, then stop.
// - Byte write: one data byte after the address, then stop.
// - Completion is polled with start plus write control byte.
module eew_host (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [eew_pkg::ADDR_W-1:0] addr_i,
  input wire logic [eew_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [eew_pkg::DATA_W-1:0] rdata_o,
  output logic scl_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);
  import eew_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  eew_state_t state, next_state;
  eew_op_t op, next_op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [4:0] byte_idx, next_byte_idx;
  logic [2:0] blk, next_blk;
  logic [7:0] waddr, next_waddr;
  logic [4:0] len, next_len;
  logic [3:0] wr_ptr, next_wr_ptr;
  logic [3:0] rd_ptr, next_rd_ptr;
  logic nack, next_nack;
  logic [7:0] rx_shift, next_rx_shift;
  logic [7:0] rx_byte, next_rx_byte;
  logic scl, next_scl;
  logic sda_oe_n, next_sda_oe_n;
  logic [DATA_W-1:0] next_rdata;
  logic [7:0] buf_mem [PAGE_DEPTH];
  logic buf_we;
  logic sda_s;
  logic busy;
  logic rd_byte;
  logic [4:0] last_idx;
  logic [7:0] cur_byte;

  eew_sync u_sda_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );

  function automatic logic [4:0] clamp_len(input logic [4:0] v);
    if (v == 5'h00)
      clamp_len = 5'h01;
    else if (v > PAGE_MAX)
      clamp_len = PAGE_MAX;
    else
      clamp_len = v;
  endfunction

  assign busy = (state != ST_IDLE);
  assign rd_byte = (op == OP_READ) && (byte_idx == 5'h01);
  assign last_idx = (op == OP_WRITE) ? 5'(len + 5'h01) : ((op == OP_READ) ? 5'h01 : 5'h00);
  assign buf_we = wr_i && !busy && (addr_i == REG_TXDATA);

  always_comb
  begin
    unique case (byte_idx)
      5'h00: cur_byte = {TYPE_CODE, blk, op == OP_READ};
      5'h01: cur_byte = waddr;
      default: cur_byte = buf_mem[rd_ptr];
    endcase
  end

  // ****************************************************************
  // Command port and bit engine
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_cnt = cnt + 1'b1;
    next_bit_cnt = bit_cnt;
    next_byte_idx = byte_idx;
    next_blk = blk;
    next_waddr = waddr;
    next_len = len;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_nack = nack;
    next_rx_shift = rx_shift;
    next_rx_byte = rx_byte;
    next_scl = scl;
    next_sda_oe_n = sda_oe_n;
    next_rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        REG_WADDR: next_rdata = DATA_W'(waddr);
        REG_LEN: next_rdata = DATA_W'(len);
        REG_STATUS:
        begin
          next_rdata[ST_BUSY_BIT] = busy;
          next_rdata[ST_NACK_BIT] = nack;
          next_rdata[ST_WPTR_LSB +: 4] = wr_ptr;
          next_rdata[ST_RX_LSB +: 8] = rx_byte;
        end
        default: next_rdata = '0;
      endcase
    end
    // Writes while a command runs are dropped so the frame stays coherent.
    if (wr_i && !busy)
    begin
      unique case (addr_i)
        REG_CMD:
        begin
          if (wdata_i[CMD_OP_LSB +: 2] != 2'h3)
          begin
            next_op = eew_op_t'(wdata_i[CMD_OP_LSB +: 2]);
            next_blk = wdata_i[CMD_BLK_LSB +: 3];
            next_state = ST_START_SU;
            next_cnt = '0;
            next_bit_cnt = '0;
            next_byte_idx = '0;
            next_rd_ptr = '0;
            next_nack = 1'b0;
          end
        end
        REG_WADDR: next_waddr = wdata_i[7:0];
        REG_LEN: next_len = clamp_len(wdata_i[4:0]);
        REG_TXDATA: next_wr_ptr = wr_ptr + 1'b1;
        default: next_len = len;
      endcase
    end
    unique case (state)
      ST_IDLE:
      begin
        next_cnt = '0;
      end
      ST_START_SU:
      begin
        // Waits out the set-up time and for the bus to read idle.
        if (cnt >= T_SU_STA_CYC - 1'b1 && sda_s)
        begin
          next_sda_oe_n = 1'b0;
          next_state = ST_START_HD;
          next_cnt = '0;
        end
      end
      ST_START_HD:
      begin
        if (cnt == T_HD_STA_CYC - 1'b1)
        begin
          next_scl = 1'b0;
          next_state = ST_BIT_LOW;
          next_cnt = '0;
        end
      end
      ST_BIT_LOW:
      begin
        // Data moves a little after the falling clock edge, never with it.
        if (cnt == T_HOLD_CYC)
        begin
          if (bit_cnt == ACK_BIT || rd_byte)
            next_sda_oe_n = 1'b1;
          else
            next_sda_oe_n = cur_byte[3'(7 - bit_cnt)];
        end
        if (cnt == T_LOW_CYC - 1'b1)
        begin
          next_scl = 1'b1;
          next_state = ST_BIT_HIGH;
          next_cnt = '0;
        end
      end
      ST_BIT_HIGH:
      begin
        if (cnt == T_HIGH_CYC - 1'b1)
        begin
          next_scl = 1'b0;
          next_cnt = '0;
          next_state = ST_BIT_LOW;
          if (bit_cnt != ACK_BIT)
          begin
            next_rx_shift = {rx_shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 1'b1;
          end
          else
          begin
            next_bit_cnt = '0;
            if (rd_byte)
            begin
              next_rx_byte = rx_shift;
              next_state = ST_STOP_LOW;
            end
            else if (sda_s)
            begin
              next_nack = 1'b1;
              next_state = ST_STOP_LOW;
            end
            else
            begin
              if (byte_idx >= 5'h02)
              begin
                next_rd_ptr = rd_ptr + 1'b1;
                next_waddr[3:0] = waddr[3:0] + 1'b1;
              end
              if (byte_idx == last_idx)
                next_state = ST_STOP_LOW;
              else
                next_byte_idx = byte_idx + 1'b1;
            end
          end
        end
      end
      ST_STOP_LOW:
      begin
        if (cnt == T_HOLD_CYC)
          next_sda_oe_n = 1'b0;
        if (cnt == T_LOW_CYC - 1'b1)
        begin
          next_scl = 1'b1;
          next_state = ST_STOP_SU;
          next_cnt = '0;
        end
      end
      ST_STOP_SU:
      begin
        if (cnt == T_SU_STO_CYC - 1'b1)
        begin
          next_sda_oe_n = 1'b1;
          next_state = ST_STOP_BUF;
          next_cnt = '0;
        end
      end
      ST_STOP_BUF:
      begin
        if (cnt == T_BUF_CYC - 1'b1)
        begin
          next_state = ST_IDLE;
          next_wr_ptr = '0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      op <= OP_WRITE;
      cnt <= '0;
      bit_cnt <= '0;
      byte_idx <= '0;
      blk <= '0;
      waddr <= WADDR_RST;
      len <= LEN_RST;
      wr_ptr <= '0;
      rd_ptr <= '0;
      nack <= 1'b0;
      rx_shift <= '0;
      rx_byte <= '0;
      scl <= 1'b1;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
      rdata_o <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      bit_cnt <= next_bit_cnt;
      byte_idx <= next_byte_idx;
      blk <= next_blk;
      waddr <= next_waddr;
      len <= next_len;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      nack <= next_nack;
      rx_shift <= next_rx_shift;
      rx_byte <= next_rx_byte;
      scl <= next_scl;
      sda_oe_n <= next_sda_oe_n;
      sda_o <= 1'b0;
      rdata_o <= next_rdata;
    end
  end

  // The page store is a memory; only its write port is clocked here.
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && buf_we)
      buf_mem[wr_ptr] <= wdata_i[7:0];
  end

  assign scl_o = scl;
  assign sda_oe_n_o = sda_oe_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);

  sequence s_ack_missed;
    state == ST_BIT_HIGH && cnt == T_HIGH_CYC - 1'b1 && bit_cnt == ACK_BIT && sda_s && !rd_byte;
  endsequence

  sequence s_high_held;
    state == ST_BIT_HIGH && $past(state) == ST_BIT_HIGH;
  endsequence

  a_sda_high_stable: assert property (s_high_held |-> $stable(sda_oe_n))
    else $error("Data moved during a clock high phase.");
  a_sda_low_change: assert property ($changed(sda_oe_n) |-> !scl ||
    state == ST_START_HD || state == ST_STOP_BUF)
    else $error("Data moved with the clock high outside start or stop.");
  a_start_shape: assert property ($fell(sda_oe_n) && scl && $past(scl) |->
    state == ST_START_HD && $past(sda_s))
    else $error("Falling data under high clock outside a start.");
  a_stop_shape: assert property ($rose(sda_oe_n) && scl && $past(scl) |->
    state == ST_STOP_BUF ##1 sda_oe_n[*3])
    else $error("Rising data under high clock outside a stop.");
  a_ack_release: assert property (state == ST_BIT_HIGH && bit_cnt == ACK_BIT |->
    sda_oe_n)
    else $error("Data not released for the acknowledge pulse.");
  a_read_nack: assert property (state == ST_BIT_HIGH && rd_byte |-> sda_oe_n)
    else $error("Read byte not left free and unacknowledged.");
  a_type_code: assert property (state == ST_BIT_HIGH && byte_idx == 5'h00 &&
    bit_cnt < 4'h4 |-> sda_oe_n == TYPE_CODE[2'(3 - bit_cnt)])
    else $error("Control byte type code wrong.");
  a_rw_bit: assert property (state == ST_BIT_HIGH && byte_idx == 5'h00 &&
    bit_cnt == 4'h7 |-> sda_oe_n == (op == OP_READ))
    else $error("Read or write bit wrong.");
  a_nack_stops: assert property (s_ack_missed |=> state == ST_STOP_LOW && nack
    ##1 (!scl)[*3])
    else $error("Missing acknowledge did not lead to a stop.");
  a_page_limit: assert property (byte_idx <= 5'(PAGE_MAX + 5'h01) &&
    len <= PAGE_MAX && len != 5'h00)
    else $error("Page length out of range.");
  a_idle_start: assert property (state == ST_START_HD && $past(state) == ST_START_SU |->
    $past(sda_s) && scl)
    else $error("Start issued on a busy bus.");
endmodule

/* File: rtl/eew_pkg.sv */
package eew_pkg;

  // ****************************************************************
  // Host register map, byte addresses on the local command port
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WADDR = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

  // Field positions.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BLK_LSB = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  localparam int ST_WPTR_LSB = 4;
  localparam int ST_RX_LSB = 8;

  // Reset values.
  localparam logic [7:0] WADDR_RST = 8'h00;
  localparam logic [4:0] LEN_RST = 5'h01;

  // ****************************************************************
  // Serial protocol constants
  // ****************************************************************
  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam int PAGE_DEPTH = 16;
  localparam logic [4:0] PAGE_MAX = 5'h10;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_POLL = 2'h1,
    OP_READ = 2'h2
  } eew_op_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_START_SU = 8'h02,
    ST_START_HD = 8'h04,
    ST_BIT_LOW = 8'h08,
    ST_BIT_HIGH = 8'h10,
    ST_STOP_LOW = 8'h20,
    ST_STOP_SU = 8'h40,
    ST_STOP_BUF = 8'h80
  } eew_state_t;

  // ****************************************************************
  // Timing, standard mode, at a 5 ns system clock
  // ****************************************************************
  localparam int MCLK_NS = 5;
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int T_SU_STA_NS = 4700;
  localparam int T_HD_STA_NS = 4000;
  localparam int T_SU_STO_NS = 4000;
  localparam int T_BUF_NS = 4700;
  localparam int T_HOLD_NS = 10;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] T_LOW_CYC = CNT_W'((T_LOW_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_HIGH_CYC = CNT_W'((T_HIGH_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_SU_STA_CYC = CNT_W'((T_SU_STA_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_HD_STA_CYC = CNT_W'((T_HD_STA_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_SU_STO_CYC = CNT_W'((T_SU_STO_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_BUF_CYC = CNT_W'((T_BUF_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [CNT_W-1:0] T_HOLD_CYC = CNT_W'((T_HOLD_NS + MCLK_NS - 1) / MCLK_NS);

endpackage

/* File: rtl/eew_sync.sv */
`timescale 1ns/1ps
module eew_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_meta = ce_i ? d_i : meta;
    next_q = ce_i ? meta : q_o;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule
